// File: common/srpg_pkg.sv
// Shared constants, register layouts and types of the SYSREF pattern generator
package srpg_pkg;

	// Register byte addresses
	localparam logic [15:0] SRPG_DIV_LOW_ADDR = 16'h0400;
	localparam logic [15:0] SRPG_DIV_HIGH_ADDR = 16'h0401;
	localparam logic [15:0] SRPG_CTL_ADDR = 16'h0402;
	localparam logic [15:0] SRPG_SRC_ADDR = 16'h0403;

	// Reset values of the four registers
	localparam logic [7:0] SRPG_DIV_LOW_RST = 8'h00;
	localparam logic [7:0] SRPG_DIV_HIGH_RST = 8'h00;
	localparam logic [7:0] SRPG_CTL_RST = 8'h00;
	localparam logic [7:0] SRPG_SRC_RST = 8'h00;

	// Answer to a read of an unmapped address
	localparam logic [7:0] SRPG_UNMAPPED_RDATA = 8'h00;

	// Source select codes
	localparam logic [1:0] SRPG_SRC_EXT = 2'h0;
	localparam logic [1:0] SRPG_SRC_EXT_RESAMP = 2'h1;
	localparam logic [1:0] SRPG_SRC_INTERNAL = 2'h2;

	// Pattern mode codes
	localparam logic [1:0] SRPG_MODE_NSHOT = 2'h0;
	localparam logic [1:0] SRPG_MODE_CONT = 2'h1;
	localparam logic [1:0] SRPG_MODE_PRBS = 2'h2;
	localparam logic [1:0] SRPG_MODE_STOP = 2'h3;

	// Test mode codes (upper bit set selects the counter clock)
	localparam logic [1:0] SRPG_TEST_LOW = 2'h0;
	localparam logic [1:0] SRPG_TEST_HIGH = 2'h1;

	// Seed of the 7-bit sequence generator, never all zero
	localparam logic [6:0] SRPG_PRBS_SEED = 7'h7f;

	// Generator states
	typedef enum logic [1:0]
	{
		SRPG_IDLE = 2'b00,
		SRPG_BURST = 2'b01,
		SRPG_RUN = 2'b10
	} srpg_state_type;

	// Clock and trigger control register, bit 7 down to bit 0
	typedef struct packed
	{
		logic method;
		logic [1:0] trig;
		logic gclk_sel;
		logic rclk_sel;
		logic [1:0] test_mode;
		logic gen_rst;
	} srpg_ctl_type;

	// Source and pattern control register, bit 7 down to bit 0
	typedef struct packed
	{
		logic [1:0] src_sel;
		logic [1:0] mode;
		logic [2:0] nshot;
		logic req;
	} srpg_src_type;

	// One register access from the serial port back end
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} srpg_bus_req_type;

	// Pulses in one burst for a count code
	function automatic logic [3:0] srpg_burst_len(input logic [2:0] code);
		logic [3:0] len;
		case (code)
			3'h2: len = 4'h2;
			3'h3: len = 4'h4;
			3'h4: len = 4'h6;
			3'h5: len = 4'h8;
			default: len = 4'h1;
		endcase
		return len;
	endfunction

endpackage

// File: logic/srpg_pulse_div.sv
// Pulse width divider: counts generator clock ticks and toggles the counter clock
module srpg_pulse_div
	import srpg_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clr,
	input wire logic tick,
	input wire logic [DIV_W-1:0] kdiv,
	output logic phase_end,
	output logic div_clk
);

	// Width check: counter must hold at least two bits
	if (DIV_W < 2 || DIV_W > 16)
	begin : g_bad_width
		$error("srpg_pulse_div: DIV_W must lie in 2..16");
	end

	logic [DIV_W-1:0] count_r; // Ticks spent in the current phase
	logic [DIV_W-1:0] count_nxt;
	logic div_clk_r; // Counter output clock, high phase first
	logic div_clk_nxt;
	logic [DIV_W-1:0] last; // Last tick of a phase

	// A zero divisor would never end a phase, so it acts as one
	assign last = (kdiv == '0) ? '0 : DIV_W'(kdiv - 1'b1);
	// Greater-or-equal so that a divisor lowered in mid-phase ends the phase at the next tick
	// instead of letting the count run on until it wraps
	assign phase_end = tick & ~clr & (count_r >= last);
	assign div_clk = div_clk_r;

	// Next count and phase
	always_comb
	begin
		count_nxt = count_r;
		div_clk_nxt = div_clk_r;
		if (clr)
		begin
			// Restart aligned: the first phase is the high one
			count_nxt = '0;
			div_clk_nxt = 1'b1;
		end
		else if (phase_end)
		begin
			// Each phase lasts kdiv ticks
			count_nxt = '0;
			div_clk_nxt = ~div_clk_r;
		end
		else if (tick)
		begin
			count_nxt = DIV_W'(count_r + 1'b1);
		end
	end

	// Register stage
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_r <= '0;
			div_clk_r <= 1'b1;
		end
		else
		begin
			count_r <= count_nxt;
			div_clk_r <= div_clk_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_div_bound: assert property ($stable(kdiv) && count_r <= last |-> count_nxt <= last)
		else $error("divider count passed the divisor");
	a_div_toggle: assert property (!clr && !phase_end |=> div_clk_r == $past(div_clk_r))
		else $error("counter clock moved without a phase end");

endmodule // srpg_pulse_div

// File: logic/srpg_gen.sv
// SYSREF pattern generator and source selector with its four control registers
module srpg_gen
	import srpg_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire srpg_bus_req_type bus_req,
	input wire logic pin_req,
	input wire logic ext_sysref,
	input wire logic synth_feedback_divider_clk,
	input wire logic reference_cleanup_loop_clk,
	input wire logic dev_clk,
	output logic [7:0] reg_rdata,
	output logic sysref_out,
	output logic test_out,
	output logic gen_active
);

	// The divisor is built from the two byte registers
	if (DIV_W < 2 || DIV_W > 16)
	begin : g_bad_width
		$error("srpg_gen: DIV_W must lie in 2..16");
	end

	// Synchroniser bit order: pin, external SYSREF, feedback clock, loop clock, device clock
	logic [4:0] sync_a_r; // First stage, read only by the second
	logic [4:0] sync_b_r; // Settled samples
	logic [4:0] sync_c_r; // Previous settled samples for edges
	logic [4:0] rise;
	logic [4:0] fall;

	// Registers
	logic [7:0] div_lo_r;
	logic [7:0] div_lo_nxt;
	logic [7:0] div_hi_r;
	logic [7:0] div_hi_nxt;
	srpg_ctl_type ctl_r;
	srpg_ctl_type ctl_nxt;
	srpg_src_type src_r;
	srpg_src_type src_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic req_prev_r; // Request bit one cycle ago

	// Generator state
	srpg_state_type state_r;
	srpg_state_type state_nxt;
	logic pend_r; // Request seen, waiting for a generator tick
	logic pend_nxt;
	logic [3:0] pulse_cnt_r; // Pulses finished in this burst
	logic [3:0] pulse_cnt_nxt;
	logic [6:0] lfsr_r; // Sequence generator
	logic [6:0] lfsr_nxt;
	logic auto_clr; // Burst done, drop the request bit

	// Output stage
	logic resamp_r; // External SYSREF caught on the resample clock
	logic resamp_nxt;
	logic sysref_r;
	logic sysref_nxt;
	logic test_r;
	logic test_nxt;
	logic active_r;

	// Decoded controls
	logic [DIV_W-1:0] kdiv;
	logic tick;
	logic rs_edge;
	logic reg_rise;
	logic req_evt;
	logic hold;
	logic start;
	logic run_mode;
	logic sw_src_wr;
	logic phase_end;
	logic div_clk;
	logic [3:0] burst_len;
	logic gen_out;

	// Every outside input but the bus request and reset passes two flops before any logic looks at it
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a_r <= 5'h00;
			sync_b_r <= 5'h00;
			sync_c_r <= 5'h00;
		end
		else
		begin
			sync_a_r <= {dev_clk, reference_cleanup_loop_clk, synth_feedback_divider_clk, ext_sysref, pin_req};
			sync_b_r <= sync_a_r;
			sync_c_r <= sync_b_r;
		end
	end

	assign rise = sync_b_r & ~sync_c_r;
	assign fall = ~sync_b_r & sync_c_r;

	// Generator clock edge, picked by the clock source bit
	assign tick = ctl_r.gclk_sel ? rise[3] : rise[2];
	// Resample clock edge, picked by the resample source bit
	assign rs_edge = ctl_r.rclk_sel ? rise[3] : rise[4];
	assign kdiv = DIV_W'({div_hi_r, div_lo_r});
	assign reg_rise = src_r.req & ~req_prev_r;
	assign run_mode = (src_r.mode == SRPG_MODE_CONT) || (src_r.mode == SRPG_MODE_PRBS);
	assign burst_len = srpg_burst_len(src_r.nshot);
	assign sw_src_wr = bus_req.wr && (bus_req.addr == SRPG_SRC_ADDR);

	// Request event and hold level for register and pin methods
	always_comb
	begin
		if (!ctl_r.method)
		begin
			// Register method: only a 0 to 1 change of the bit counts
			req_evt = reg_rise;
			hold = src_r.req;
		end
		else if (ctl_r.trig[1])
		begin
			// Edge trigger: once started, only reset or stop ends the run
			req_evt = ctl_r.trig[0] ? fall[0] : rise[0];
			hold = 1'b1;
		end
		else
		begin
			// Level trigger, active high
			req_evt = rise[0];
			hold = sync_b_r[0];
		end
	end

	// Start only on a generator tick so pulses align to that clock
	assign start = (pend_r | req_evt) & tick & (state_r == SRPG_IDLE)
		& (src_r.mode != SRPG_MODE_STOP) & ~ctl_r.gen_rst;

	srpg_pulse_div #(
		.DIV_W(DIV_W)
	) u_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clr(ctl_r.gen_rst | start),
		.tick(tick),
		.kdiv(kdiv),
		.phase_end(phase_end),
		.div_clk(div_clk)
	);

	// Register file next values and read data
	always_comb
	begin
		div_lo_nxt = div_lo_r;
		div_hi_nxt = div_hi_r;
		ctl_nxt = ctl_r;
		src_nxt = src_r;
		rdata_nxt = rdata_r;
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				SRPG_DIV_LOW_ADDR: div_lo_nxt = bus_req.wdata;
				SRPG_DIV_HIGH_ADDR: div_hi_nxt = bus_req.wdata;
				SRPG_CTL_ADDR: ctl_nxt = srpg_ctl_type'(bus_req.wdata);
				SRPG_SRC_ADDR: src_nxt = srpg_src_type'(bus_req.wdata);
				default: ;
			endcase
		end
		// A software write in the same cycle beats the automatic clear
		if (auto_clr && !sw_src_wr)
		begin
			src_nxt.req = 1'b0;
		end
		if (bus_req.rd)
		begin
			// The request bit reads back live, so software sees a burst end
			case (bus_req.addr)
				SRPG_DIV_LOW_ADDR: rdata_nxt = div_lo_r;
				SRPG_DIV_HIGH_ADDR: rdata_nxt = div_hi_r;
				SRPG_CTL_ADDR: rdata_nxt = ctl_r;
				SRPG_SRC_ADDR: rdata_nxt = src_r;
				default: rdata_nxt = SRPG_UNMAPPED_RDATA;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_lo_r <= SRPG_DIV_LOW_RST;
			div_hi_r <= SRPG_DIV_HIGH_RST;
			ctl_r <= srpg_ctl_type'(SRPG_CTL_RST);
			src_r <= srpg_src_type'(SRPG_SRC_RST);
			rdata_r <= 8'h00;
			req_prev_r <= 1'b0;
		end
		else
		begin
			div_lo_r <= div_lo_nxt;
			div_hi_r <= div_hi_nxt;
			ctl_r <= ctl_nxt;
			src_r <= src_nxt;
			rdata_r <= rdata_nxt;
			req_prev_r <= src_r.req;
		end
	end

	// Generator state machine next values
	always_comb
	begin
		state_nxt = state_r;
		pend_nxt = pend_r;
		pulse_cnt_nxt = pulse_cnt_r;
		lfsr_nxt = lfsr_r;
		auto_clr = 1'b0;
		// Pending request waits for the next tick
		if (state_r != SRPG_IDLE || start || src_r.mode == SRPG_MODE_STOP || (run_mode && !hold))
		begin
			pend_nxt = 1'b0;
		end
		else if (req_evt)
		begin
			pend_nxt = 1'b1;
		end
		case (state_r)
			SRPG_IDLE:
			begin
				pulse_cnt_nxt = 4'h0;
				if (start)
				begin
					state_nxt = run_mode ? SRPG_RUN : SRPG_BURST;
					lfsr_nxt = SRPG_PRBS_SEED;
				end
			end
			SRPG_BURST:
			begin
				// A pulse ends with its high phase
				if (phase_end && div_clk)
				begin
					pulse_cnt_nxt = 4'(pulse_cnt_r + 4'h1);
					if (4'(pulse_cnt_r + 4'h1) == burst_len)
					begin
						state_nxt = SRPG_IDLE;
						auto_clr = ~ctl_r.method;
					end
				end
			end
			SRPG_RUN:
			begin
				// Sequence advances once per full divided period
				if (phase_end && !div_clk)
				begin
					lfsr_nxt = {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
				end
				if (!hold)
				begin
					state_nxt = SRPG_IDLE;
				end
			end
			default: state_nxt = SRPG_IDLE;
		endcase
		// Stop mode and generator reset both end any pattern at once
		if (src_r.mode == SRPG_MODE_STOP || ctl_r.gen_rst)
		begin
			state_nxt = SRPG_IDLE;
			pend_nxt = 1'b0;
			pulse_cnt_nxt = 4'h0;
		end
	end

	// Generator state storage
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= SRPG_IDLE;
			pend_r <= 1'b0;
			pulse_cnt_r <= 4'h0;
			lfsr_r <= SRPG_PRBS_SEED;
		end
		else
		begin
			state_r <= state_nxt;
			pend_r <= pend_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
			lfsr_r <= lfsr_nxt;
		end
	end

	// Internal pattern level
	always_comb
	begin
		case (state_r)
			SRPG_BURST: gen_out = div_clk;
			SRPG_RUN: gen_out = (src_r.mode == SRPG_MODE_PRBS) ? lfsr_r[0] : div_clk;
			default: gen_out = 1'b0;
		endcase
	end

	// Output selection and resampling
	always_comb
	begin
		resamp_nxt = rs_edge ? sync_b_r[1] : resamp_r;
		case (src_r.src_sel)
			SRPG_SRC_EXT: sysref_nxt = sync_b_r[1];
			SRPG_SRC_EXT_RESAMP: sysref_nxt = resamp_r;
			SRPG_SRC_INTERNAL: sysref_nxt = gen_out & ~ctl_r.gen_rst;
			default: sysref_nxt = 1'b0;
		endcase
		if (ctl_r.test_mode[1])
		begin
			test_nxt = div_clk;
		end
		else
		begin
			test_nxt = (ctl_r.test_mode == SRPG_TEST_HIGH);
		end
	end

	// Output flops
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			resamp_r <= 1'b0;
			sysref_r <= 1'b0;
			test_r <= 1'b0;
			active_r <= 1'b0;
		end
		else
		begin
			resamp_r <= resamp_nxt;
			sysref_r <= sysref_nxt;
			test_r <= test_nxt;
			active_r <= (state_nxt != SRPG_IDLE);
		end
	end

	assign reg_rdata = rdata_r;
	assign sysref_out = sysref_r;
	assign test_out = test_r;
	assign gen_active = active_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_div_high_write: assert property (bus_req.wr && bus_req.addr == SRPG_DIV_HIGH_ADDR
		|=> div_hi_r == $past(bus_req.wdata))
		else $error("high divisor byte not written");
	a_reg_method_only: assert property (!ctl_r.method && !reg_rise && !pend_r |-> !start)
		else $error("start without a register request");
	a_gen_clk_src: assert property (start |-> (ctl_r.gclk_sel ? rise[3] : rise[2]))
		else $error("start not on the selected generator clock");
	a_resamp_hold: assert property (!rs_edge |=> resamp_r == $past(resamp_r))
		else $error("resample changed without its clock edge");
	a_test_forced: assert property (ctl_r.test_mode == SRPG_TEST_HIGH |=> test_r)
		else $error("test output not forced high");
	a_src_external: assert property (src_r.src_sel == SRPG_SRC_EXT |=> sysref_r == $past(sync_b_r[1]))
		else $error("external source not passed through");
	a_stop_idle: assert property (src_r.mode == SRPG_MODE_STOP |=> state_r == SRPG_IDLE)
		else $error("pattern running in stop mode");
	a_burst_count: assert property (state_r == SRPG_BURST |-> pulse_cnt_r < burst_len)
		else $error("burst sent too many pulses");
	a_burst_clear: assert property (auto_clr && !sw_src_wr |=> !src_r.req ##1 state_r == SRPG_IDLE)
		else $error("request bit not cleared after burst");
	a_run_stop: assert property (state_r == SRPG_RUN && !ctl_r.method && !src_r.req
		&& !ctl_r.gen_rst |=> state_r == SRPG_IDLE)
		else $error("run did not stop on cleared request");
	a_gen_reset: assert property (ctl_r.gen_rst |=> state_r == SRPG_IDLE ##1 !sysref_r || src_r.src_sel != SRPG_SRC_INTERNAL)
		else $error("generator reset did not idle the pattern");
	a_start_aligned: assert property (state_r == SRPG_IDLE ##1 state_r != SRPG_IDLE |-> $past(tick))
		else $error("pattern start not on a generator tick");

	c_burst_done: cover property (state_r == SRPG_BURST ##1 state_r == SRPG_IDLE);
	c_prbs_run: cover property (state_r == SRPG_RUN && src_r.mode == SRPG_MODE_PRBS);
	c_pin_fall_start: cover property (ctl_r.method && ctl_r.trig == 2'h3 && start);
	c_set_beats_clear: cover property (auto_clr && sw_src_wr);

endmodule // srpg_gen

// File: dv/srpg_clk_model.sv
// Far-side clock sources: feedback divider, cleanup loop and device clock
module srpg_clk_model
#(
	parameter int FB_HALF = 16,
	parameter int CL_HALF = 24,
	parameter int DV_HALF = 20
)
(
	output logic fb_clk,
	output logic cl_clk,
	output logic dv_clk
);
	timeunit 1ns;
	timeprecision 1ns;

	// Free-running device clocks; the 1 ns offset keeps every edge off a ref_clk edge
	initial
	begin
		fb_clk = 1'b0;
		cl_clk = 1'b0;
		dv_clk = 1'b0;
		#1;
		fork
			forever #(FB_HALF) fb_clk = ~fb_clk;
			forever #(CL_HALF) cl_clk = ~cl_clk;
			forever #(DV_HALF) dv_clk = ~dv_clk;
		join
	end
endmodule // srpg_clk_model

// File: dv/tb_top.sv
// Self-checking bench of the SYSREF pattern generator
module tb_top
	import srpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk; // Main clock, 4 ns
	logic rstn; // Active-low reset
	srpg_bus_req_type bus_req; // Register access
	logic pin_req; // Request pin
	logic ext_sysref; // External SYSREF
	logic fb_clk; // Feedback divider clock, 8 cycles
	logic cl_clk; // Cleanup loop clock, 12 cycles
	logic dv_clk; // Device clock, 10 cycles
	logic [7:0] reg_rdata;
	logic sysref_out;
	logic test_out;
	logic gen_active;
	int err_count;
	int cmp_count;

	// Main clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	srpg_gen #(.DIV_W(16)) DUT (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .pin_req(pin_req),
		.ext_sysref(ext_sysref), .synth_feedback_divider_clk(fb_clk), .reference_cleanup_loop_clk(cl_clk),
		.dev_clk(dv_clk), .reg_rdata(reg_rdata), .sysref_out(sysref_out), .test_out(test_out),
		.gen_active(gen_active));

	srpg_clk_model clks (.fb_clk(fb_clk), .cl_clk(cl_clk), .dv_clk(dv_clk));

	// Compare and count
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write strobe, launched off the falling edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus_req = {1'b1, 1'b0, a, d};
		@(negedge ref_clk);
		bus_req = '0;
	endtask

	// Read; data is taken a full cycle after the strobe so it has surely landed
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		bus_req = {1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk);
		bus_req = '0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	// Counts rising edges of the SYSREF or test output over a window
	task automatic rises(input bit tst, input int cyc, output int n);
		logic prev;
		logic cur;
		n = 0;
		prev = tst ? test_out : sysref_out;
		repeat (cyc)
		begin
			@(negedge ref_clk);
			cur = tst ? test_out : sysref_out;
			if (cur === 1'b1 && prev === 1'b0)
				n++;
			prev = cur;
		end
	endtask

	// Length of the next high phase of the SYSREF output, both waits bounded
	task automatic hi_width(output int w);
		int t;
		t = 0;
		w = 0;
		while (sysref_out !== 1'b1 && t < 5000)
		begin
			@(negedge ref_clk);
			t++;
		end
		while (sysref_out === 1'b1 && w < 5000)
		begin
			@(negedge ref_clk);
			w++;
		end
	endtask

	// Reset values, read-back and an unmapped place
	task automatic t_regs;
		logic [7:0] d;
		for (int i = 0; i < 4; i++)
		begin
			rd(16'(SRPG_DIV_LOW_ADDR + i), d);
			chk("reset value", SRPG_CTL_RST, d);
		end
		wr(SRPG_DIV_LOW_ADDR, 8'h5a);
		wr(SRPG_DIV_HIGH_ADDR, 8'ha5);
		wr(16'h0404, 8'hff);
		rd(SRPG_DIV_LOW_ADDR, d);
		chk("divisor low", 8'h5a, d);
		rd(SRPG_DIV_HIGH_ADDR, d);
		chk("divisor high", 8'ha5, d);
		rd(16'h0404, d);
		chk("unmapped read", SRPG_UNMAPPED_RDATA, d);
		wr(SRPG_DIV_LOW_ADDR, 8'h01);
		wr(SRPG_DIV_HIGH_ADDR, 8'h00);
	endtask

	// Every burst count code, and the request bit clearing itself
	task automatic t_burst;
		int n;
		logic [7:0] d;
		int en [8] = '{1, 1, 2, 4, 6, 8, 1, 1};
		for (int c = 0; c < 8; c++)
		begin
			wr(SRPG_SRC_ADDR, {2'b10, 2'b00, 3'(c), 1'b1});
			rises(0, 200, n);
			chk("burst pulses", 16'(en[c]), 16'(n));
			rd(SRPG_SRC_ADDR, d);
			chk("burst request bit", 16'h0, 16'(d[0]));
		end
	endtask

	// Pulse width from both divisor bytes, zero divisor and either clock source
	task automatic t_width;
		int w;
		logic [7:0] kl [4] = '{8'h00, 8'h02, 8'h00, 8'h01};
		logic [7:0] kh [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
		logic [7:0] cs [4] = '{8'h00, 8'h00, 8'h00, 8'h10};
		int ew [4] = '{8, 16, 2048, 12};
		for (int i = 0; i < 4; i++)
		begin
			wr(SRPG_DIV_LOW_ADDR, kl[i]);
			wr(SRPG_DIV_HIGH_ADDR, kh[i]);
			wr(SRPG_CTL_ADDR, cs[i]);
			wr(SRPG_SRC_ADDR, 8'h83);
			hi_width(w);
			chk("pulse width", 16'(ew[i]), 16'(w));
		end
		wr(SRPG_CTL_ADDR, 8'h00);
	endtask

	// Pin requests: rising edge, falling edge, level; register request ignored
	task automatic t_pin;
		int n;
		logic [7:0] cs [3] = '{8'hc0, 8'he0, 8'h80};
		wr(SRPG_SRC_ADDR, 8'h82);
		for (int i = 0; i < 3; i++)
		begin
			wr(SRPG_CTL_ADDR, cs[i]);
			repeat (10) @(negedge ref_clk);
			pin_req = ~pin_req;
			rises(0, 100, n);
			chk("pin pulses", 16'h1, 16'(n));
		end
		pin_req = 1'b0;
		wr(SRPG_SRC_ADDR, 8'h83);
		rises(0, 100, n);
		chk("register request in pin method", 16'h0, 16'(n));
		wr(SRPG_SRC_ADDR, 8'h82);
		wr(SRPG_CTL_ADDR, 8'h00);
	endtask

	// Continuous run held by the bit, stop mode, sequence mode, generator reset
	task automatic t_cont;
		int n;
		logic [7:0] d;
		wr(SRPG_SRC_ADDR, 8'h93);
		rises(0, 160, n);
		chk("continuous runs", 16'h1, 16'(n >= 9));
		rd(SRPG_SRC_ADDR, d);
		chk("continuous bit held", 16'h1, 16'(d[0]));
		// Software clears the bit before any new request
		wr(SRPG_SRC_ADDR, 8'h92);
		repeat (4) @(negedge ref_clk);
		rises(0, 60, n);
		chk("continuous stopped", 16'h0, 16'({gen_active, 8'(n)}));
		wr(SRPG_SRC_ADDR, 8'hb1);
		rises(0, 100, n);
		chk("stop mode", 16'h0, 16'(n));
		wr(SRPG_SRC_ADDR, 8'hb0);
		wr(SRPG_SRC_ADDR, 8'ha1);
		rises(0, 400, n);
		chk("sequence runs", 16'h1, 16'(n > 0));
		wr(SRPG_CTL_ADDR, 8'h01);
		repeat (4) @(negedge ref_clk);
		rises(0, 100, n);
		chk("generator reset", 16'h0, 16'({gen_active, sysref_out, 8'(n)}));
		wr(SRPG_CTL_ADDR, 8'h00);
		wr(SRPG_SRC_ADDR, 8'ha0);
	endtask

	// Test output: high, low, then the counter clock of a running wave
	task automatic t_test;
		int n;
		wr(SRPG_CTL_ADDR, 8'h02);
		repeat (3) @(negedge ref_clk);
		chk("test high", 16'h1, 16'(test_out));
		wr(SRPG_CTL_ADDR, 8'h00);
		repeat (3) @(negedge ref_clk);
		chk("test low", 16'h0, 16'(test_out));
		wr(SRPG_CTL_ADDR, 8'h04);
		wr(SRPG_SRC_ADDR, 8'h93);
		rises(1, 160, n);
		chk("test counter clock", 16'h1, 16'(n >= 9));
		wr(SRPG_SRC_ADDR, 8'h92);
		wr(SRPG_CTL_ADDR, 8'h00);
	endtask

	// External source direct, resampled on device clock, resampled on cleanup clock
	task automatic t_ext;
		logic [7:0] cs [3] = '{8'h00, 8'h00, 8'h08};
		logic [7:0] ss [3] = '{8'h00, 8'h40, 8'h40};
		for (int i = 0; i < 3; i++)
		begin
			wr(SRPG_CTL_ADDR, cs[i]);
			wr(SRPG_SRC_ADDR, ss[i]);
			ext_sysref = 1'b1;
			repeat (30) @(negedge ref_clk);
			chk("external high", 16'h1, 16'(sysref_out));
			ext_sysref = 1'b0;
			repeat (30) @(negedge ref_clk);
			chk("external low", 16'h0, 16'(sysref_out));
		end
	endtask

	// Verdict and end of run
	task automatic print_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		err_count = 0;
		cmp_count = 0;
		bus_req = '0;
		pin_req = 1'b0;
		ext_sysref = 1'b0;
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		t_regs;
		t_burst;
		t_width;
		t_pin;
		t_cont;
		t_test;
		t_ext;
		print_verdict;
	end

	// Watchdog, well past the roughly 22 us the tests need
	initial
	begin
		#100000;
		err_count++;
		print_verdict;
	end
endmodule // tb_top
